// *** include/pep_params.svh ***
// Timing counts and constants for the parallel byte-memory host controller
`ifndef PEP_PARAMS_SVH
`define PEP_PARAMS_SVH
// ==========================================================================
// Clock
// ==========================================================================
`define PEP_CLK_NS          100
// ==========================================================================
// Array geometry
// ==========================================================================
`define PEP_ADDR_W          11
`define PEP_DATA_W          8
`define PEP_ID_FIRST        11'h7E0
`define PEP_ID_LAST         11'h7FF
// ==========================================================================
// Strobe timing (ns as printed, cycles derived)
// ==========================================================================
`define PEP_RD_ACC_NS       350
`define PEP_RD_ACC_CYC      ((`PEP_RD_ACC_NS + `PEP_CLK_NS - 1) / `PEP_CLK_NS)
`define PEP_WE_PULSE_NS     100
`define PEP_WE_PULSE_CYC    ((`PEP_WE_PULSE_NS + `PEP_CLK_NS - 1) / `PEP_CLK_NS)
`define PEP_SETUP_NS        50
`define PEP_SETUP_CYC       ((`PEP_SETUP_NS + `PEP_CLK_NS - 1) / `PEP_CLK_NS)
// ==========================================================================
// Long times
// ==========================================================================
`define PEP_CLEAR_MS        10
`define PEP_CLEAR_CYC       ((`PEP_CLEAR_MS * 1000000) / `PEP_CLK_NS)
`define PEP_PROG_US         1000
`define PEP_PROG_CYC        ((`PEP_PROG_US * 1000) / `PEP_CLK_NS)
`endif

// *** include/pep_pkg.sv ***
// Types shared by the host controller files
package pep_pkg;
    // =====================================================================
    // Controller states
    // =====================================================================
    typedef enum logic [3:0]
    {
        PEP_IDLE,
        PEP_RD_WAIT,
        PEP_RD_DONE,
        PEP_WR_SETUP,
        PEP_WR_PULSE,
        PEP_WR_HOLD,
        PEP_POLL_RD,
        PEP_POLL_GAP,
        PEP_CLR_SETUP,
        PEP_CLR_PULSE,
        PEP_CLR_HOLD
    } pep_state_t;
    // Request kinds
    typedef enum logic [1:0]
    {
        PEP_OP_READ,
        PEP_OP_WRITE,
        PEP_OP_CLEAR
    } pep_op_t;
endpackage

// *** rtl/pep_sync2.sv ***
// Two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
module pep_sync2
    import pep_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // =====================================================================
    // Stages
    // =====================================================================
    logic [W-1:0] s1_reg;   // First stage, read only by the second
    logic [W-1:0] q_reg;    // Second stage
    logic [W-1:0] s1_next;
    logic [W-1:0] q_next;

    // Next values
    always_comb
    begin
        s1_next = d;
        q_next  = s1_reg;
    end

    // Register both stages
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            q_reg  <= '0;
        end
        else
        begin
            s1_reg <= s1_next;
            q_reg  <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// *** rtl/pep_host.sv ***
// Host controller driving a parallel byte-writable nonvolatile memory
`timescale 1ns/1ps
`include "pep_params.svh"
module pep_host
    import pep_pkg::*;
#(
    parameter int ADDR_W    = `PEP_ADDR_W,
    parameter int DATA_W    = `PEP_DATA_W,
    parameter int CLEAR_CYC = `PEP_CLEAR_CYC,
    parameter int PROG_CYC  = `PEP_PROG_CYC
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    input  wire pep_op_t           req_op,
    input  wire logic              req_id_space,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_timeout,
    output logic                   mem_ce_n,
    output logic                   mem_oe_n,
    output logic                   mem_oe_hv,
    output logic                   mem_we_n,
    output logic                   id_space_select_line,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      mem_dq_out,
    output logic                   mem_dq_oe,
    input  wire logic [DATA_W-1:0] mem_dq_in
);
    // =====================================================================
    // Elaboration checks
    // =====================================================================
    // Refused at elaboration, so a bad build never reaches simulation
    if (ADDR_W != 11 || DATA_W != 8)
    begin
        $error("pep_host serves only an 11-bit by 8-bit array");
    end
    if (CLEAR_CYC < 1 || PROG_CYC < 1)
    begin
        $error("pep_host counts must be at least one cycle");
    end

    localparam int CNT_W = 32;
    localparam int TOP   = DATA_W - 1;
    // Poll budget: three programming times before giving up
    localparam logic [CNT_W-1:0] POLL_LIMIT = CNT_W'(PROG_CYC * 3);

    // =====================================================================
    // Synchronised data inputs
    // =====================================================================
    logic [DATA_W-1:0] dq_sync;     // Pin data after two flops

    pep_sync2 #(.W(DATA_W)) u_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (mem_dq_in),
        .q     (dq_sync)
    );

    // =====================================================================
    // State
    // =====================================================================
    pep_state_t        state_reg,   state_next;
    logic [CNT_W-1:0]  cnt_reg,     cnt_next;     // Phase timer
    logic [CNT_W-1:0]  poll_reg,    poll_next;    // Poll budget
    logic [ADDR_W-1:0] addr_reg,    addr_next;
    logic [DATA_W-1:0] wdata_reg,   wdata_next;
    logic              id_reg,      id_next;
    logic              ce_n_reg,    ce_n_next;
    logic              oe_n_reg,    oe_n_next;
    logic              hv_reg,      hv_next;
    logic              we_n_reg,    we_n_next;
    logic              dq_oe_reg,   dq_oe_next;
    logic              ready_reg,   ready_next;
    logic              rvalid_reg,  rvalid_next;
    logic [DATA_W-1:0] rdata_reg,   rdata_next;
    logic              tmo_reg,     tmo_next;

    // Read settle: access time plus two sync flops
    localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(`PEP_RD_ACC_CYC + 2);
    localparam logic [CNT_W-1:0] WE_CYC  = CNT_W'(`PEP_WE_PULSE_CYC);
    localparam logic [CNT_W-1:0] SU_CYC  = CNT_W'(`PEP_SETUP_CYC);
    localparam logic [CNT_W-1:0] CLR_CYC = CNT_W'(CLEAR_CYC);

    // Next-state logic for the strobe sequencer
    always_comb
    begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        poll_next   = poll_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        id_next     = id_reg;
        ce_n_next   = ce_n_reg;
        oe_n_next   = oe_n_reg;
        hv_next     = hv_reg;
        we_n_next   = we_n_reg;
        dq_oe_next  = dq_oe_reg;
        ready_next  = ready_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        tmo_next    = 1'b0;
        case (state_reg)
            PEP_IDLE:
            begin
                // Idle: everything deasserted, bus released
                ce_n_next  = 1'b1;
                oe_n_next  = 1'b1;
                we_n_next  = 1'b1;
                hv_next    = 1'b0;
                dq_oe_next = 1'b0;
                if (req_valid && ready_reg)
                begin
                    ready_next = 1'b0;
                    addr_next  = req_addr;
                    wdata_next = req_wdata;
                    // ID bytes live only in the top 32 addresses
                    id_next    = req_id_space && (req_addr >= `PEP_ID_FIRST);
                    cnt_next   = '0;
                    case (req_op)
                        PEP_OP_READ:
                        begin
                            state_next = PEP_RD_WAIT;
                            ce_n_next  = 1'b0;
                            oe_n_next  = 1'b0;
                        end
                        PEP_OP_WRITE:
                        begin
                            // Data and address set up with OE high first
                            state_next = PEP_WR_SETUP;
                            dq_oe_next = 1'b1;
                            ce_n_next  = 1'b0;
                        end
                        PEP_OP_CLEAR:
                        begin
                            state_next = PEP_CLR_SETUP;
                            ce_n_next  = 1'b0;
                            hv_next    = 1'b1;
                        end
                        default:
                            ready_next = 1'b1;
                    endcase
                end
            end
            PEP_RD_WAIT:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg + 1'b1 >= RD_CYC)
                begin
                    rdata_next  = dq_sync;
                    // Raising both ends the read and floats the device
                    ce_n_next   = 1'b1;
                    oe_n_next   = 1'b1;
                    rvalid_next = 1'b1;
                    state_next  = PEP_RD_DONE;
                end
            end
            PEP_RD_DONE:
            begin
                ready_next = 1'b1;
                state_next = PEP_IDLE;
            end
            PEP_WR_SETUP:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg + 1'b1 >= SU_CYC)
                begin
                    // WE falls last, so the address is taken here
                    we_n_next  = 1'b0;
                    cnt_next   = '0;
                    state_next = PEP_WR_PULSE;
                end
            end
            PEP_WR_PULSE:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg + 1'b1 >= WE_CYC)
                begin
                    // WE rises first; data is held one more cycle
                    we_n_next  = 1'b1;
                    state_next = PEP_WR_HOLD;
                end
            end
            PEP_WR_HOLD:
            begin
                ce_n_next  = 1'b1;
                dq_oe_next = 1'b0;
                poll_next  = '0;
                cnt_next   = '0;
                state_next = PEP_POLL_GAP;
            end
            PEP_POLL_GAP:
            begin
                // Device programs on its own; host only watches
                poll_next = poll_reg + 1'b1;
                ce_n_next = 1'b0;
                oe_n_next = 1'b0;
                cnt_next  = '0;
                state_next = PEP_POLL_RD;
            end
            PEP_POLL_RD:
            begin
                cnt_next  = cnt_reg + 1'b1;
                poll_next = poll_reg + 1'b1;
                if (cnt_reg + 1'b1 >= RD_CYC)
                begin
                    ce_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    // Inverted top bit means still busy
                    if (dq_sync[TOP] == wdata_reg[TOP])
                    begin
                        rdata_next  = dq_sync;
                        rvalid_next = 1'b1;
                        state_next  = PEP_RD_DONE;
                    end
                    else if (poll_reg >= POLL_LIMIT)
                    begin
                        // Limitation: a dead part is reported, not retried
                        rdata_next  = dq_sync;
                        rvalid_next = 1'b1;
                        tmo_next    = 1'b1;
                        state_next  = PEP_RD_DONE;
                    end
                    else
                        state_next = PEP_POLL_GAP;
                end
            end
            PEP_CLR_SETUP:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg + 1'b1 >= SU_CYC)
                begin
                    we_n_next  = 1'b0;
                    cnt_next   = '0;
                    state_next = PEP_CLR_PULSE;
                end
            end
            PEP_CLR_PULSE:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg + 1'b1 >= CLR_CYC)
                begin
                    we_n_next  = 1'b1;
                    state_next = PEP_CLR_HOLD;
                end
            end
            PEP_CLR_HOLD:
            begin
                ce_n_next   = 1'b1;
                hv_next     = 1'b0;
                rvalid_next = 1'b1;
                rdata_next  = {DATA_W{1'b1}};
                state_next  = PEP_RD_DONE;
            end
            default:
            begin
                state_next = PEP_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    // Register the sequencer; idle strobes are all high, high voltage off, bus released
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg  <= PEP_IDLE;
            cnt_reg    <= '0;
            poll_reg   <= '0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            id_reg     <= 1'b0;
            ce_n_reg   <= 1'b1;
            oe_n_reg   <= 1'b1;
            hv_reg     <= 1'b0;
            we_n_reg   <= 1'b1;
            dq_oe_reg  <= 1'b0;
            ready_reg  <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            tmo_reg    <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            poll_reg   <= poll_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            id_reg     <= id_next;
            ce_n_reg   <= ce_n_next;
            oe_n_reg   <= oe_n_next;
            hv_reg     <= hv_next;
            we_n_reg   <= we_n_next;
            dq_oe_reg  <= dq_oe_next;
            ready_reg  <= ready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            tmo_reg    <= tmo_next;
        end
    end

    // =====================================================================
    // Outputs, all straight from flops
    // =====================================================================
    assign req_ready            = ready_reg;
    assign rsp_valid            = rvalid_reg;
    assign rsp_rdata            = rdata_reg;
    assign rsp_timeout          = tmo_reg;
    assign mem_ce_n             = ce_n_reg;
    assign mem_oe_n             = oe_n_reg;
    assign mem_oe_hv            = hv_reg;
    assign mem_we_n             = we_n_reg;
    assign id_space_select_line = id_reg;
    assign mem_addr             = addr_reg;
    assign mem_dq_out           = wdata_reg;
    assign mem_dq_oe            = dq_oe_reg;
endmodule

// *** verification/pep_host_properties.sv ***
// Concurrent checks on the host controller memory pins and response signals
`timescale 1ns/1ps
module pep_host_properties
    import pep_pkg::*;
#(
    parameter int CLEAR_CYC = 20
)
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        rsp_timeout,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_oe_hv,
    input wire logic        mem_we_n,
    input wire logic        id_space_select_line,
    input wire logic [10:0] mem_addr,
    input wire logic [7:0]  mem_dq_out,
    input wire logic        mem_dq_oe
);
    // ======================================================================
    // Write strobe low-time counter
    // ======================================================================
    int low_cnt_reg;  // Cycles the write strobe has stayed low
    int low_cnt_next;
    // Count restarts whenever the strobe is high
    always_comb
    begin
        low_cnt_next = mem_we_n ? 0 : low_cnt_reg + 1;
    end
    always_ff @(posedge clk)
    begin
        low_cnt_reg <= rst_n ? low_cnt_next : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ======================================================================
    // Properties
    // ======================================================================
    property p_bus_free;
        (!mem_ce_n && !mem_oe_n) |-> !mem_dq_oe;
    endproperty
    property p_no_wr_read;
        !mem_we_n |-> mem_oe_n && !mem_ce_n;
    endproperty
    property p_wr_addr;
        (!mem_we_n && !mem_oe_hv) |-> mem_dq_oe && $stable(mem_addr);
    endproperty
    property p_data_hold;
        ($rose(mem_we_n) && !mem_oe_hv) |-> mem_dq_oe && $stable(mem_dq_out);
    endproperty
    property p_clear_len;
        ($rose(mem_we_n) && mem_oe_hv) |-> low_cnt_reg >= CLEAR_CYC;
    endproperty
    property p_hv_ce;
        mem_oe_hv |-> !mem_ce_n;
    endproperty
    property p_id_range;
        id_space_select_line |-> mem_addr >= 11'h7E0;
    endproperty
    property p_rd_hold;
        $fell(mem_oe_n) |-> (!mem_oe_n && !mem_ce_n)[*4];
    endproperty
    property p_rd_end;
        rsp_valid |-> mem_oe_n;
    endproperty
    property p_tmo;
        rsp_timeout |-> rsp_valid ##1 req_ready;
    endproperty
    a_bus_free: assert property (p_bus_free) else $error("host drives during read");
    a_no_wr_read: assert property (p_no_wr_read) else $error("bad write strobe");
    a_wr_addr: assert property (p_wr_addr) else $error("write addr moved");
    a_data_hold: assert property (p_data_hold) else $error("write data moved");
    a_clear_len: assert property (p_clear_len) else $error("clear pulse short");
    a_hv_ce: assert property (p_hv_ce) else $error("high voltage without select");
    a_id_range: assert property (p_id_range) else $error("id select out of range");
    a_rd_hold: assert property (p_rd_hold) else $error("read cut short");
    a_rd_end: assert property (p_rd_end) else $error("read not ended");
    a_tmo: assert property (p_tmo) else $error("bad timeout pulse");
    c_clear: cover property ($rose(mem_we_n) && mem_oe_hv);
    c_tmo: cover property (rsp_timeout);
    c_id: cover property (id_space_select_line && !mem_we_n);
endmodule

// *** verification/pep_mem_model.sv ***
// Behavioural model of the byte-writable memory behind the host pins
`timescale 1ns/1ps
module pep_mem_model
#(
    parameter int FAST_NS  = 3000,
    parameter int SLOW_NS  = 20000,
    parameter int CLEAR_NS = 2000
)
(
    input  wire logic        slow,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        oe_hv,
    input  wire logic        we_n,
    input  wire logic        id_sel,
    input  wire logic [10:0] addr,
    input  wire logic [7:0]  din,
    output logic      [7:0]  dq
);
    logic [7:0] arr [0:2079];  // Main bytes, then 32 id bytes
    logic [7:0] wbyte;         // Byte being programmed
    logic [7:0] last_dq = 8'h00;
    logic       busy = 1'b0;
    int         widx = 0;
    int         lidx = 0;
    realtime    t_fall = 0;
    bit         armed = 1'b0;  // Set by a real write start, so the X-to-0 step at reset cannot program
    wire wr_on = !ce_n && !we_n && oe_n && !oe_hv;
    wire rd_on = !ce_n && !oe_n;
    wire [7:0] rd_byte;
    // Id bytes only answer with the select raised
    function automatic int idx_of(input logic s, input logic [10:0] a);
        return (s && a >= 11'h7E0) ? 2048 + int'(a[4:0]) : int'(a);
    endfunction
    initial foreach (arr[i]) arr[i] = 8'h00;
    // Address on the later falling edge
    always @(posedge wr_on)
    begin
        widx = idx_of(id_sel, addr);
        armed = 1'b1;
    end
    // Data on the earlier rising edge, then self-timed program
    always @(negedge wr_on)
        if (armed)
        begin
            armed = 1'b0;
            wbyte = din;
            lidx = widx;
            busy = 1'b1;
            #(slow ? SLOW_NS : FAST_NS);
            arr[lidx] = wbyte;
            busy = 1'b0;
        end
    // Clear needs a long enough strobe under high voltage
    always @(negedge we_n) t_fall = $realtime;
    always @(posedge we_n)
        if (!ce_n && oe_hv && $realtime - t_fall >= CLEAR_NS)
            for (int i = 0; i < 2048; i++) arr[i] = 8'hFF;
    // Busy byte shows inverted top bit
    assign rd_byte = (busy && idx_of(id_sel, addr) == lidx) ? {~wbyte[7], arr[lidx][6:0]}
                   : arr[idx_of(id_sel, addr)];
    // Released lines show junk, never the last value
    always @* if (rd_on) last_dq = rd_byte;
    assign dq = rd_on ? rd_byte : ~last_dq;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the host controller with a memory model
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_top;
    import pep_pkg::*;
    localparam int CLR = 20;         // Shortened clear pulse in cycles
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_id_space = 1'b0, slow = 1'b0;
    pep_op_t     req_op = PEP_OP_READ;
    logic [10:0] req_addr = '0, mem_addr;
    logic [7:0]  req_wdata = '0, rsp_rdata, mem_dq_out, dev_dq;
    logic        req_ready, rsp_valid, rsp_timeout, mem_ce_n, mem_oe_n, mem_oe_hv;
    logic        mem_we_n, id_space_select_line, mem_dq_oe;
    logic [7:0]  exp_mem [0:2079];   // Expected contents, id bytes at the end
    int          n_errors = 0;
    int          checked = 0;
    wire  [7:0]  bus = mem_dq_oe ? mem_dq_out : dev_dq;  // Resolved data lines
    pep_host #(.CLEAR_CYC(CLR), .PROG_CYC(50)) dut
    (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_id_space(req_id_space), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_timeout(rsp_timeout), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
        .mem_oe_hv(mem_oe_hv), .mem_we_n(mem_we_n), .id_space_select_line(id_space_select_line),
        .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(bus)
    );
    pep_mem_model #(.CLEAR_NS(CLR * 100)) u_mem
    (
        .slow(slow), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .oe_hv(mem_oe_hv), .we_n(mem_we_n),
        .id_sel(id_space_select_line), .addr(mem_addr), .din(bus), .dq(dev_dq)
    );
    // Location a request lands on
    function automatic int ix(input logic s, input logic [10:0] a);
        return (s && a >= 11'h7E0) ? 2048 + int'(a[4:0]) : int'(a);
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One request, held until the accept edge, then a bounded wait for the answer
    task automatic do_op(input pep_op_t op, input logic s, input logic [10:0] a,
                         input logic [7:0] d, output logic [7:0] rd, output logic tmo);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_op = op;
        req_id_space = s;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        rd = rsp_rdata;
        tmo = rsp_timeout;
        if (n >= 400)
        begin
            n_errors++;
            finish_test();
        end
        @(posedge clk);
        #1;
    endtask
    initial forever #50 clk = ~clk;
    initial
    begin
        logic [7:0]  rd, d;
        logic [10:0] a;
        logic        tmo, s;
        void'($urandom(43));
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        `CHK("idle strobes", 4'hE, {mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe})
        // Whole-array clear, id bytes untouched
        do_op(PEP_OP_CLEAR, 1'b0, 11'h000, 8'h00, rd, tmo);
        `CHK("clear rsp", 8'hFF, rd)
        foreach (exp_mem[i]) exp_mem[i] = (i < 2048) ? 8'hFF : 8'h00;
        do_op(PEP_OP_READ, 1'b0, 11'h7FF, 8'h00, rd, tmo);
        `CHK("cleared byte", 8'hFF, rd)
        // Writes at random and corner places, each polled then read in both spaces
        for (int i = 0; i < 14; i++)
        begin
            s = (i % 4 == 3);
            d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
            a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7FF : (i == 2) ? 11'h7E0
              : s ? {6'h3F, 5'($urandom)} : 11'($urandom_range(0, 2047));
            do_op(PEP_OP_WRITE, s, a, d, rd, tmo);
            `CHK("poll bit7", d[7], rd[7])
            `CHK("no timeout", 1'b0, tmo)
            exp_mem[ix(s, a)] = d;
            do_op(PEP_OP_READ, s, a, 8'h00, rd, tmo);
            `CHK("readback", exp_mem[ix(s, a)], rd)
            do_op(PEP_OP_READ, ~s, a, 8'h00, rd, tmo);
            `CHK("other space", exp_mem[ix(~s, a)], rd)
        end
        // Unused request code is dropped: port stays ready, no answer, pins idle
        req_valid = 1'b1;
        req_op = pep_op_t'(2'h3);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        @(posedge clk);
        #1;
        `CHK("dropped code", 6'h2E, {req_ready, rsp_valid, mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe})
        // Slow programming runs past the poll budget
        slow = 1'b1;
        do_op(PEP_OP_WRITE, 1'b0, 11'h123, 8'h5A, rd, tmo);
        `CHK("slow timeout", 1'b1, tmo)
        `CHK("busy bit7", 1'b1, rd[7])
        repeat (250) @(posedge clk);
        #1;
        slow = 1'b0;
        do_op(PEP_OP_READ, 1'b0, 11'h123, 8'h00, rd, tmo);
        `CHK("after slow", 8'h5A, rd)
        finish_test();
    end
endmodule
bind pep_host pep_host_properties #(.CLEAR_CYC(CLEAR_CYC)) u_props
(
    .clk(clk), .rst_n(rst_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_timeout(rsp_timeout), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_oe_hv(mem_oe_hv), .mem_we_n(mem_we_n), .id_space_select_line(id_space_select_line),
    .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe)
);
